/* File: pkg/bms_pkg.sv */
// package: constants, types and states of the boot mode selector
package bms_pkg;

    // strap bit positions within the sampled strap vector
    localparam int STRAP_ONE_POS = 0; // async_serial_transmit, strap_pin_one
    localparam int STRAP_TWO_POS = 1; // serial_port_transmit_data, strap_pin_two
    localparam int STRAP_THREE_POS = 2; // spi_slave_select, strap_pin_three
    localparam int STRAP_FOUR_POS = 3; // spi_serial_clock, strap_pin_four

    // pull-up enables per strap: only strap one has one
    localparam logic [3:0] STRAP_PULLUP_EN = 4'h1;

    // entry points of the on-chip memories
    localparam logic [21:0] ENTRY_FLASH = 22'h3f7ff6;
    localparam logic [21:0] ENTRY_SARAM = 22'h3f8000;
    localparam logic [21:0] ENTRY_OTP = 22'h3d7800;
    localparam logic [21:0] ENTRY_NONE = 22'h000000;

    // edges after reset release before the strap synchronisers hold pin levels
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;
    localparam logic [1:0] SETTLE_RESET = 2'h0;
    localparam logic [3:0] STRAP_RESET = 4'h0;

    // boot actions
    typedef enum logic [2:0] {
        BMS_MODE_NONE = 3'h0,
        BMS_MODE_FLASH = 3'h1,
        BMS_MODE_SPI_LOAD = 3'h2,
        BMS_MODE_UART_LOAD = 3'h3,
        BMS_MODE_SARAM = 3'h4,
        BMS_MODE_OTP = 3'h5,
        BMS_MODE_PARALLEL_LOAD = 3'h6
    } bms_mode_type;

    // command handed to the cpu start logic or a loader
    typedef struct packed {
        bms_mode_type mode;
        logic load_external; // a loader pulls code in from outside
        logic [21:0] entry_addr; // branch target, zero for loader modes
    } bms_cmd_type;

    localparam bms_cmd_type CMD_RESET = '{BMS_MODE_NONE, 1'b0, ENTRY_NONE};

    // sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_SETTLE = 5'h01,
        ST_SAMPLE = 5'h02,
        ST_ISSUE = 5'h04,
        ST_RUN = 5'h08,
        ST_EXTERN = 5'h10
    } bms_state_type;

endpackage

/* File: logic/bms_boot_mode_selector.sv */
// boot mode selector: samples straps after reset and issues one boot action
// Function
// RULE1: every reset, sample four straps, choose mode
// RULE2: strap one high selects flash entry
// RULE3: straps 0,1 select spi loader
// RULE4: straps 0,0,1,1 select uart loader
// RULE5: straps 0,0,1,0 branch to ram entry
// RULE6: straps 0,0,0,1 branch to otp entry
// RULE7: all straps low select parallel loader
// RULE8: pull-up only on strap one
// RULE9: memory modes load no external code
// RULE10: user programs branch at flash entry
// RULE11: board checks spi clock strap side effects
// RULE12: microprocessor mode disables rom, skips decode
// RULE13: sample once, hold mode until started
`timescale 1ns/1ps

module bms_boot_mode_selector (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] strap_pins_i, // raw strap levels, asynchronous
    input wire logic microprocessor_mode_pin_i, // raw mode pin, asynchronous
    input wire logic boot_ack_i, // selected branch or loader has started
    output logic [3:0] strap_pullup_en_o, // pull-up enable per strap pin
    output logic boot_req_o, // command valid, held until acknowledged
    output bms_pkg::bms_cmd_type boot_cmd_o, // decoded boot command
    output logic rom_disable_o, // boot rom off, vectors fetched externally
    output logic boot_busy_o // selection still in progress
);

    // two-stage synchronisers for the pins
    logic [3:0] strap_meta_q;
    logic [3:0] strap_sync_q;
    logic mp_meta_q;
    logic mp_sync_q;

    // sequencer and captured state
    bms_pkg::bms_state_type state_q;
    bms_pkg::bms_state_type state_d;
    logic [1:0] settle_q;
    logic [3:0] strap_q; // levels captured at the single sample point
    logic mp_q; // mode pin captured at the same point
    bms_pkg::bms_cmd_type cmd_q;

    // decode wires
    logic s_one;
    logic s_two;
    logic s_three;
    logic s_four;
    logic settle_done;
    bms_pkg::bms_mode_type dec_mode;
    logic dec_load;
    logic [21:0] dec_addr;
    bms_pkg::bms_cmd_type dec_cmd;

    // synchronisers: only the second stage is read anywhere
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_meta_q <= bms_pkg::STRAP_RESET;
            strap_sync_q <= bms_pkg::STRAP_RESET;
            mp_meta_q <= 1'b0;
            mp_sync_q <= 1'b0;
        end else begin
            strap_meta_q <= strap_pins_i;
            strap_sync_q <= strap_meta_q;
            mp_meta_q <= microprocessor_mode_pin_i;
            mp_sync_q <= mp_meta_q;
        end
    end

    // strap decode, priority follows strap one down to strap four
    assign s_one = strap_sync_q[bms_pkg::STRAP_ONE_POS];
    assign s_two = strap_sync_q[bms_pkg::STRAP_TWO_POS];
    assign s_three = strap_sync_q[bms_pkg::STRAP_THREE_POS];
    assign s_four = strap_sync_q[bms_pkg::STRAP_FOUR_POS];
    assign dec_mode = s_one ? bms_pkg::BMS_MODE_FLASH : // RULE2
        s_two ? bms_pkg::BMS_MODE_SPI_LOAD : // RULE3
        (s_three && s_four) ? bms_pkg::BMS_MODE_UART_LOAD : // RULE4
        s_three ? bms_pkg::BMS_MODE_SARAM : // RULE5
        s_four ? bms_pkg::BMS_MODE_OTP : // RULE6
        bms_pkg::BMS_MODE_PARALLEL_LOAD; // RULE7
    // memory modes only branch, loaders pull code in
    assign dec_load = (dec_mode == bms_pkg::BMS_MODE_SPI_LOAD) ||
        (dec_mode == bms_pkg::BMS_MODE_UART_LOAD) ||
        (dec_mode == bms_pkg::BMS_MODE_PARALLEL_LOAD); // RULE9
    assign dec_addr = (dec_mode == bms_pkg::BMS_MODE_FLASH) ? bms_pkg::ENTRY_FLASH : // RULE2
        (dec_mode == bms_pkg::BMS_MODE_SARAM) ? bms_pkg::ENTRY_SARAM : // RULE5
        (dec_mode == bms_pkg::BMS_MODE_OTP) ? bms_pkg::ENTRY_OTP : // RULE6
        bms_pkg::ENTRY_NONE;
    assign dec_cmd = '{dec_mode, dec_load, dec_addr};
    assign settle_done = (settle_q == bms_pkg::SETTLE_CYCLES);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            // wait until the synchronisers carry real pin levels
            bms_pkg::ST_SETTLE: begin
                if (settle_done) begin
                    state_d = bms_pkg::ST_SAMPLE; // RULE1
                end
            end
            // single sample point; mode pin high skips decode entirely
            bms_pkg::ST_SAMPLE: begin
                if (mp_sync_q) begin
                    state_d = bms_pkg::ST_EXTERN; // RULE12
                end else begin
                    state_d = bms_pkg::ST_ISSUE;
                end
            end
            // hold the request until the target reports it has started
            bms_pkg::ST_ISSUE: begin
                if (boot_ack_i) begin
                    state_d = bms_pkg::ST_RUN; // RULE13
                end
            end
            // terminal states, left only by reset
            bms_pkg::ST_RUN: begin
                state_d = bms_pkg::ST_RUN;
            end
            bms_pkg::ST_EXTERN: begin
                state_d = bms_pkg::ST_EXTERN;
            end
            default: begin
                state_d = bms_pkg::ST_SETTLE;
            end
        endcase
    end

    // sequencer state and settle counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= bms_pkg::ST_SETTLE;
            settle_q <= bms_pkg::SETTLE_RESET;
        end else begin
            state_q <= state_d;
            if (!settle_done) begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    // capture once per reset; never rewritten afterwards so the mode is stable
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            strap_q <= bms_pkg::STRAP_RESET;
            mp_q <= 1'b0;
            cmd_q <= bms_pkg::CMD_RESET;
        end else if (state_q == bms_pkg::ST_SAMPLE) begin
            strap_q <= strap_sync_q; // RULE1
            mp_q <= mp_sync_q; // RULE12
            if (!mp_sync_q) begin
                cmd_q <= dec_cmd; // RULE13
            end
        end
    end

    // outputs
    assign strap_pullup_en_o = bms_pkg::STRAP_PULLUP_EN; // RULE8
    assign boot_req_o = (state_q == bms_pkg::ST_ISSUE);
    assign boot_cmd_o = cmd_q;
    assign rom_disable_o = mp_q; // RULE12
    // busy until a terminal state is reached
    assign boot_busy_o = (state_q != bms_pkg::ST_RUN) && (state_q != bms_pkg::ST_EXTERN);

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    localparam int SETTLE_MIN = 1;
    localparam int SETTLE_MAX = 4;

    sequence s_sample_then_act;
        (state_q == bms_pkg::ST_SAMPLE) ##1
            (state_q == bms_pkg::ST_ISSUE || state_q == bms_pkg::ST_EXTERN);
    endsequence

    property p_sample_after_reset;
        (state_q == bms_pkg::ST_SETTLE) |-> ##[SETTLE_MIN:SETTLE_MAX] s_sample_then_act;
    endproperty
    a_sample_after_reset: assert property (p_sample_after_reset) // RULE1
        else $error("straps not sampled in time after reset");

    property p_flash;
        (state_q == bms_pkg::ST_ISSUE && strap_q[0]) |->
            (boot_cmd_o.mode == bms_pkg::BMS_MODE_FLASH &&
             boot_cmd_o.entry_addr == 22'h3f7ff6);
    endproperty
    a_flash: assert property (p_flash) // RULE2
        else $error("strap one high did not give flash entry");

    property p_spi;
        (state_q == bms_pkg::ST_ISSUE && strap_q[1:0] == 2'h2) |->
            (boot_cmd_o.mode == bms_pkg::BMS_MODE_SPI_LOAD && boot_cmd_o.load_external);
    endproperty
    a_spi: assert property (p_spi) // RULE3
        else $error("straps 0,1 did not give spi loader");

    property p_uart;
        (state_q == bms_pkg::ST_ISSUE && strap_q == 4'hc) |->
            (boot_cmd_o.mode == bms_pkg::BMS_MODE_UART_LOAD);
    endproperty
    a_uart: assert property (p_uart) // RULE4
        else $error("straps 0,0,1,1 did not give uart loader");

    property p_saram;
        (state_q == bms_pkg::ST_ISSUE && strap_q == 4'h4) |->
            (boot_cmd_o.mode == bms_pkg::BMS_MODE_SARAM &&
             boot_cmd_o.entry_addr == 22'h3f8000);
    endproperty
    a_saram: assert property (p_saram) // RULE5
        else $error("straps 0,0,1,0 did not give ram entry");

    property p_otp;
        (state_q == bms_pkg::ST_ISSUE && strap_q == 4'h8) |->
            (boot_cmd_o.mode == bms_pkg::BMS_MODE_OTP &&
             boot_cmd_o.entry_addr == 22'h3d7800);
    endproperty
    a_otp: assert property (p_otp) // RULE6
        else $error("straps 0,0,0,1 did not give otp entry");

    property p_parallel;
        (state_q == bms_pkg::ST_ISSUE && strap_q == 4'h0) |->
            (boot_cmd_o.mode == bms_pkg::BMS_MODE_PARALLEL_LOAD && boot_cmd_o.load_external);
    endproperty
    a_parallel: assert property (p_parallel) // RULE7
        else $error("all straps low did not give parallel loader");

    property p_pullup;
        strap_pullup_en_o == 4'h1;
    endproperty
    a_pullup: assert property (p_pullup) // RULE8
        else $error("pull-up enables wrong");

    property p_no_load;
        (boot_req_o && boot_cmd_o.entry_addr != 22'h000000) |-> !boot_cmd_o.load_external;
    endproperty
    a_no_load: assert property (p_no_load) // RULE9
        else $error("memory mode marked as loading code");

    property p_extern;
        (state_q == bms_pkg::ST_SAMPLE && mp_sync_q) |=>
            (rom_disable_o && !boot_req_o && boot_cmd_o.mode == bms_pkg::BMS_MODE_NONE) [*3];
    endproperty
    a_extern: assert property (p_extern) // RULE12
        else $error("microprocessor mode did not disable rom");

    property p_hold;
        (boot_req_o && !boot_ack_i) |=> (boot_req_o && $stable(boot_cmd_o));
    endproperty
    a_hold: assert property (p_hold) // RULE13
        else $error("request or command dropped before acknowledge");

    property p_stable_after;
        (state_q == bms_pkg::ST_RUN) |=> $stable(boot_cmd_o) && !boot_req_o;
    endproperty
    a_stable_after: assert property (p_stable_after) // RULE13
        else $error("command changed after start");

endmodule

/* File: sim/bms_board_model.sv */
// board model: strap pin levels and the start acknowledge of the boot target
`timescale 1ns/1ps

module bms_board_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] strap_level_i, // level the board drives
    input wire logic [3:0] strap_float_i, // strap left undriven
    input wire logic [3:0] pullup_en_i, // on-chip pull-up per strap
    input wire logic boot_req_i, // boot command valid
    input wire logic [3:0] ack_delay_i, // request cycles before the target starts
    input wire logic stray_ack_i, // ack raised outside any request
    output logic [3:0] strap_pins_o, // resolved strap pin levels
    output logic boot_ack_o // target has started
);
    logic wobble_q; // flips every cycle: an open line has no stable level
    logic [3:0] wait_q; // cycles the request has been waiting
    logic [3:0] open_level; // what an undriven strap shows
    // pulled-up straps read high, the others wander so no level is trusted
    assign open_level = pullup_en_i | ({4{wobble_q}} & ~pullup_en_i);
    // board drives the spi clock strap as a static level unless left open, when it toggles every cycle
    assign strap_pins_o = (strap_level_i & ~strap_float_i) |
        (open_level & strap_float_i);
    // flash image is assumed to hold its branch, so flash starts like any target
    assign boot_ack_o = (boot_req_i && (wait_q >= ack_delay_i)) || stray_ack_i;
    // request wait counter and open-line pattern
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 4'h0;
            wobble_q <= 1'b0;
        end else begin
            wobble_q <= ~wobble_q;
            wait_q <= boot_req_i ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule

/* File: sim/testbench.sv */
// self-checking bench of the boot mode selector with a board model
`timescale 1ns/1ps

`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %0t %s", $time, msg); end end

module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] strap_level = 4'h0; // board strap drive
    logic [3:0] strap_float = 4'h0; // straps left open
    logic mode_pin = 1'b0; // microprocessor mode pin
    logic [3:0] ack_delay = 4'h0; // target start latency
    logic stray_ack = 1'b0; // ack outside a request
    logic [3:0] strap_pins;
    logic boot_ack;
    logic [3:0] pullup_en;
    logic boot_req;
    bms_pkg::bms_cmd_type boot_cmd;
    logic rom_disable;
    logic boot_busy;
    int n_fail = 0;
    int checks = 0;
    logic [31:0] seed = 32'h00000046; // xorshift state, fixed start

    bms_boot_mode_selector bms_boot_mode_selector_inst (.clk_i(clk_i), .rst_i(rst_i),
        .strap_pins_i(strap_pins), .microprocessor_mode_pin_i(mode_pin),
        .boot_ack_i(boot_ack), .strap_pullup_en_o(pullup_en), .boot_req_o(boot_req),
        .boot_cmd_o(boot_cmd), .rom_disable_o(rom_disable), .boot_busy_o(boot_busy));
    bms_board_model bms_board_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .strap_level_i(strap_level), .strap_float_i(strap_float), .pullup_en_i(pullup_en),
        .boot_req_i(boot_req), .ack_delay_i(ack_delay), .stray_ack_i(stray_ack),
        .strap_pins_o(strap_pins), .boot_ack_o(boot_ack));

    // 100 MHz clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // pseudo-random source, repeatable
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected command from strap levels and mode pin, strap one first
    function automatic bms_pkg::bms_cmd_type exp_cmd(input logic [3:0] s, input logic mp);
        bms_pkg::bms_cmd_type c;
        c = '{bms_pkg::BMS_MODE_NONE, 1'b0, 22'h000000};
        if (mp) return c;
        if (s[0]) c = '{bms_pkg::BMS_MODE_FLASH, 1'b0, 22'h3f7ff6};
        else if (s[1]) c = '{bms_pkg::BMS_MODE_SPI_LOAD, 1'b1, 22'h000000};
        else if (s[3:2] == 2'b11) c = '{bms_pkg::BMS_MODE_UART_LOAD, 1'b1, 22'h000000};
        else if (s[3:2] == 2'b01) c = '{bms_pkg::BMS_MODE_SARAM, 1'b0, 22'h3f8000};
        else if (s[3:2] == 2'b10) c = '{bms_pkg::BMS_MODE_OTP, 1'b0, 22'h3d7800};
        else c = '{bms_pkg::BMS_MODE_PARALLEL_LOAD, 1'b1, 22'h000000};
        return c;
    endfunction

    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // one reset and boot: straps, open mask, mode pin, ack delay, abort, stray ack
    task automatic run_boot(input logic [3:0] s, input logic [3:0] f, input logic mp,
                            input logic [3:0] d, input bit abort, input bit stray);
        bms_pkg::bms_cmd_type e;
        int n;
        e = exp_cmd(s | f, mp);
        @(posedge clk_i);
        #1;
        rst_i = 1'b1;
        strap_level = s;
        strap_float = f;
        mode_pin = mp;
        ack_delay = d;
        @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        stray_ack = stray;
        repeat (3) @(posedge clk_i);
        #1;
        stray_ack = 1'b0;
        `CHK(boot_req, 1'b0, "request before capture")
        `CHK(boot_busy, 1'b1, "idle before capture")
        @(posedge clk_i);
        #1;
        `CHK(boot_cmd, e, "boot command")
        `CHK(boot_cmd.load_external, e.load_external, "external load flag")
        `CHK(boot_req, ~mp, "request level")
        `CHK(rom_disable, mp, "rom disable")
        `CHK(pullup_en, 4'h1, "pull-up enables")
        strap_level = ~s;
        mode_pin = ~mp;
        if (abort) begin
            rst_i = 1'b1;
            #1;
            `CHK(boot_req, 1'b0, "request in reset")
            `CHK(boot_cmd, 26'h0000000, "command in reset")
            return;
        end
        n = 0;
        while (boot_req === 1'b1 && n < 12) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        `CHK(n, mp ? 0 : d + 1, "request hold until start")
        `CHK(boot_busy, 1'b0, "busy after start")
        `CHK(boot_cmd, e, "command after strap change")
    endtask

    // watchdog
    initial begin
        #200000;
        n_fail++;
        tally_and_finish();
    end

    // main sequence: one strap pattern per boot mode, corners, then random straps
    initial begin
        logic [31:0] r;
        logic [3:0] pat [6];
        pat = '{4'h1, 4'h2, 4'hc, 4'h4, 4'h8, 4'h0};
        repeat (16) @(posedge clk_i);
        for (int i = 0; i < 6; i++) run_boot(pat[i], 4'h0, 1'b0, i[3:0], 1'b0, 1'b0);
        run_boot(4'h0, 4'hf, 1'b0, 4'h2, 1'b0, 1'b0);
        run_boot(4'h6, 4'h0, 1'b1, 4'h0, 1'b0, 1'b0);
        run_boot(4'h2, 4'h0, 1'b0, 4'h5, 1'b1, 1'b0);
        run_boot(4'hc, 4'h0, 1'b0, 4'h3, 1'b0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            run_boot(r[3:0], 4'h0, r[7:5] == 3'h0, {1'b0, r[10:8]}, r[15:12] == 4'h0,
                     r[16]);
        end
        tally_and_finish();
    end
endmodule
